// *** hw/mclkpg_top.sv ***
// main clock prescaler with per-module clock enables
`timescale 1ns/100ps
module mclkpg_top (
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              div_we_i,
    input  wire logic [mclkpg_pkg::DIV_W-1:0]      div_wdata_i,
    input  wire logic                              ahb_mask_we_i,
    input  wire logic [mclkpg_pkg::NUM_AHB-1:0]    ahb_mask_wdata_i,
    input  wire logic                              apb_mask_we_i,
    input  wire logic [mclkpg_pkg::NUM_APB-1:0]    apb_mask_wdata_i,
    input  wire logic                              ien_set_i,
    input  wire logic                              ien_clr_i,
    input  wire logic                              flag_clr_i,
    input  wire logic                              wprot_i,
    input  wire logic                              dbg_access_i,
    input  wire logic                              dbg_attached_i,
    input  wire logic                              sleep_i,
    input  wire logic                              cpu_stop_i,
    output logic [mclkpg_pkg::DIV_W-1:0]           div_rdata_o,
    output logic                                   clock_ready_flag_o,
    output logic                                   irq_en_o,
    output logic [mclkpg_pkg::NUM_AHB-1:0]         ahb_mask_o,
    output logic [mclkpg_pkg::NUM_APB-1:0]         apb_mask_o,
    output logic                                   cpu_clk_en_o,
    output logic [mclkpg_pkg::NUM_AHB-1:0]         system_bus_clock_en_o,
    output logic [mclkpg_pkg::NUM_APB-1:0]         peripheral_bus_clock_en_o,
    output logic                                   prot_violation_o,
    output logic                                   irq_o
);
    logic                            rs1_r, rst_n;
    logic [7:0]                      div_r, div_nxt, act_r, act_nxt, cnt_r, cnt_nxt;
    logic [15:0]                     ahbm_r, ahbm_nxt;
    logic [31:0]                     apbm_r, apbm_nxt;
    logic                            flag_r, flag_nxt, ien_r, ien_nxt, viol_r, viol_nxt;
    logic                            tick, wr_ok, div_ok;
    mclkpg_pkg::mclkpg_state_t       st_r, st_nxt;
    logic                            cpu_en_r, cpu_en_nxt;
    logic [15:0]                     ahb_en_r, ahb_en_nxt;
    logic [31:0]                     apb_en_r, apb_en_nxt;
    logic                            keep_run;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // legal divider: a power of two from 1 to 128
    function automatic logic div_legal(input logic [7:0] d);
        return (d != 8'h00) && ((d & (d - 8'h01)) == 8'h00) && (d <= mclkpg_pkg::DIV_MAX);
    endfunction : div_legal

    assign wr_ok  = !wprot_i || dbg_access_i;
    assign div_ok = div_legal(div_wdata_i);
    assign tick   = (cnt_r == 8'h00);

    always_comb begin
        div_nxt  = div_r;
        act_nxt  = act_r;
        cnt_nxt  = tick ? (act_r - 8'h01) : (cnt_r - 8'h01);
        ahbm_nxt = ahbm_r;
        apbm_nxt = apbm_r;
        ien_nxt  = ien_r;
        viol_nxt = 1'b0;
        st_nxt   = st_r;
        flag_nxt = flag_r;
        // a rewrite while a switch is pending (WAIT or APPLY) is refused and flagged
        if (div_we_i) begin
            if (!wr_ok || st_r != mclkpg_pkg::MCLKPG_IDLE) begin
                viol_nxt = 1'b1;
            end else begin
                div_nxt  = div_wdata_i;
                flag_nxt = 1'b0;
                viol_nxt = !div_ok;
                st_nxt   = div_ok ? mclkpg_pkg::MCLKPG_WAIT : mclkpg_pkg::MCLKPG_APPLY;
            end
        end
        if (flag_clr_i) begin
            flag_nxt = 1'b0;
        end
        unique case (st_r)
            mclkpg_pkg::MCLKPG_IDLE: ;
            // switch only on a period boundary so no short pulse appears
            mclkpg_pkg::MCLKPG_WAIT: begin
                if (tick) begin
                    act_nxt = div_r;
                    cnt_nxt = div_r - 8'h01;
                    st_nxt  = mclkpg_pkg::MCLKPG_APPLY;
                end
            end
            mclkpg_pkg::MCLKPG_APPLY: begin
                flag_nxt = 1'b1;
                st_nxt   = mclkpg_pkg::MCLKPG_IDLE;
            end
        endcase
        if (ahb_mask_we_i && wr_ok) begin
            ahbm_nxt = ahb_mask_wdata_i;
        end
        // own clock off means the apb mask is unreachable until reset; the ahb mask stays writable
        if (apb_mask_we_i && wr_ok && apbm_r[mclkpg_pkg::OWN_APB_BIT]) begin
            apbm_nxt = apb_mask_wdata_i;
        end
        if (ien_set_i && wr_ok) begin
            ien_nxt = 1'b1;
        end else if (ien_clr_i && wr_ok) begin
            ien_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= mclkpg_pkg::DIV_RST;
            act_r  <= mclkpg_pkg::DIV_RST;
            cnt_r  <= 8'h00;
            ahbm_r <= mclkpg_pkg::AHB_MASK_RST;
            apbm_r <= mclkpg_pkg::APB_MASK_RST;
            flag_r <= 1'b1;
            ien_r  <= 1'b0;
            viol_r <= 1'b0;
            st_r   <= mclkpg_pkg::MCLKPG_IDLE;
        end else begin
            div_r  <= div_nxt;
            act_r  <= act_nxt;
            cnt_r  <= cnt_nxt;
            ahbm_r <= ahbm_nxt;
            apbm_r <= apbm_nxt;
            flag_r <= flag_nxt;
            ien_r  <= ien_nxt;
            viol_r <= viol_nxt;
            st_r   <= st_nxt;
        end
    end

    // sleep stops the cpu only; debugger keeps the cpu clock alive in sleep, cpu stop still wins
    assign keep_run = dbg_attached_i || !sleep_i;

    always_comb begin
        cpu_en_nxt = tick && !cpu_stop_i && keep_run;
        ahb_en_nxt = {mclkpg_pkg::NUM_AHB{tick}} & ahbm_r;
        apb_en_nxt = {mclkpg_pkg::NUM_APB{tick}} & apbm_r;
    end

    // registered enables feed latch-free gates downstream: no glitch possible
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_en_r <= 1'b0;
            ahb_en_r <= '0;
            apb_en_r <= '0;
        end else begin
            cpu_en_r <= cpu_en_nxt;
            ahb_en_r <= ahb_en_nxt;
            apb_en_r <= apb_en_nxt;
        end
    end

    assign cpu_clk_en_o              = cpu_en_r;
    assign system_bus_clock_en_o     = ahb_en_r;
    assign peripheral_bus_clock_en_o = apb_en_r;
    assign div_rdata_o               = div_r;
    assign clock_ready_flag_o        = flag_r;
    assign irq_en_o                  = ien_r;
    assign ahb_mask_o                = ahbm_r;
    assign apb_mask_o                = apbm_r;
    assign prot_violation_o          = viol_r;
    assign irq_o                     = flag_r && ien_r;

    // enables are registered, so each answers the mask, tick and sleep/stop inputs of the cycle before
    a_irq_follows_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
        (flag_clr_i && st_r != mclkpg_pkg::MCLKPG_APPLY) |=> !irq_o)
        else $error("irq stayed after flag clear");
    a_flag_low_after_wr: assert property (@(posedge clk_i) disable iff (!rst_n)
        (div_we_i && wr_ok && st_r == mclkpg_pkg::MCLKPG_IDLE && div_ok)
        |=> !clock_ready_flag_o) else $error("flag not cleared");
    // worst case: a full 128 period before the switch, then one apply cycle
    a_flag_sets_bounded: assert property (@(posedge clk_i) disable iff (!rst_n)
        (st_r == mclkpg_pkg::MCLKPG_WAIT) |-> ##[1:130] clock_ready_flag_o)
        else $error("flag never set");
    a_bad_div_flagged: assert property (@(posedge clk_i) disable iff (!rst_n)
        (div_we_i && wr_ok && st_r == mclkpg_pkg::MCLKPG_IDLE && !div_ok)
        |=> prot_violation_o && $stable(act_r)) else $error("bad divider used");
    a_prot_blocks_wr: assert property (@(posedge clk_i) disable iff (!rst_n)
        (ahb_mask_we_i && wprot_i && !dbg_access_i) |=> $stable(ahb_mask_o))
        else $error("protected write took");
    a_dbg_bypass: assert property (@(posedge clk_i) disable iff (!rst_n)
        (ahb_mask_we_i && dbg_access_i) |=> ahb_mask_o == $past(ahb_mask_wdata_i))
        else $error("debug write lost");
    a_own_clk_sticky: assert property (@(posedge clk_i) disable iff (!rst_n)
        !apb_mask_o[mclkpg_pkg::OWN_APB_BIT] |=> !apb_mask_o[mclkpg_pkg::OWN_APB_BIT])
        else $error("own clock revived");
    a_cpu_stops: assert property (@(posedge clk_i) disable iff (!rst_n)
        cpu_stop_i |=> !cpu_clk_en_o)
        else $error("cpu clock ran");
    a_bus_aligned: assert property (@(posedge clk_i) disable iff (!rst_n)
        cpu_clk_en_o |-> peripheral_bus_clock_en_o == $past(apb_mask_o)
        && system_bus_clock_en_o == $past(ahb_mask_o)) else $error("bus clocks out of phase");
    a_masked_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        (peripheral_bus_clock_en_o & ~$past(apb_mask_o)) == '0
        && (system_bus_clock_en_o & ~$past(ahb_mask_o)) == '0) else $error("masked clock ran");
    a_reload_count: assert property (@(posedge clk_i) disable iff (!rst_n)
        tick |=> cnt_r == act_r - 8'h01)
        else $error("prescaler reload wrong");

    // sleep and debugger: the cpu may stop, the bus clocks never do
    a_bus_in_sleep: assert property (@(posedge clk_i) disable iff (!rst_n)
        (tick && sleep_i) |=> peripheral_bus_clock_en_o == $past(apb_mask_o)
        && system_bus_clock_en_o == $past(ahb_mask_o)) else $error("bus clock stopped in sleep");
    a_sleep_cpu_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sleep_i && !dbg_attached_i) |=> !cpu_clk_en_o)
        else $error("cpu clock ran in sleep");
    a_dbg_keeps_cpu: assert property (@(posedge clk_i) disable iff (!rst_n)
        (tick && sleep_i && dbg_attached_i && !cpu_stop_i) |=> cpu_clk_en_o)
        else $error("cpu clock lost with debugger");
    a_irq_disabled: assert property (@(posedge clk_i) disable iff (!rst_n)
        (ien_clr_i && !ien_set_i && wr_ok) |=> !irq_o)
        else $error("irq with enable cleared");
    a_flag_clr_free: assert property (@(posedge clk_i) disable iff (!rst_n)
        (flag_clr_i && wprot_i && !dbg_access_i && st_r == mclkpg_pkg::MCLKPG_IDLE)
        |=> !clock_ready_flag_o) else $error("flag clear blocked");
endmodule : mclkpg_top

// *** hw/mclkpg_pkg.sv ***
// constants for the main clock prescaler and gating block
package mclkpg_pkg;
    localparam int          DIV_W        = 8;
    localparam int          NUM_AHB      = 16;
    localparam int          NUM_APB      = 32;
    localparam logic [7:0]  DIV_RST      = 8'h01;
    localparam logic [7:0]  DIV_MAX      = 8'h80;
    localparam logic [15:0] AHB_MASK_RST = 16'h01FF;
    localparam logic [31:0] APB_MASK_RST = 32'h000FFFFF;
    localparam int          OWN_APB_BIT  = 1;
    typedef enum logic [1:0] {MCLKPG_IDLE, MCLKPG_WAIT, MCLKPG_APPLY} mclkpg_state_t;
endpackage : mclkpg_pkg

// *** tb/mclkpg_consumer.sv ***
// behavioural clock consumer counting the enabled cycles it receives
`timescale 1ns/100ps
module mclkpg_consumer (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       cpu_en_i,
    input  wire logic       bus_en_i,
    output logic [7:0]      cpu_cnt_o,
    output logic [7:0]      bus_cnt_o
);
    // one cpu tick runs one step, one bus tick serves one access
    always_ff @(posedge clk_i) begin
        cpu_cnt_o <= clr_i ? 8'h00 : cpu_cnt_o + {7'h00, cpu_en_i};
        bus_cnt_o <= clr_i ? 8'h00 : bus_cnt_o + {7'h00, bus_en_i};
    end
endmodule : mclkpg_consumer

// *** tb/tb.sv ***
// self-checking bench for the main clock prescaler and gating block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
    logic        clk_i, rst_n_i, div_we, ahb_we, apb_we, ien_set, ien_clr, flag_clr, clr;
    logic        wprot, dbg_acc, dbg_att, sleep, cpu_stop, flag, ien, cpu_en, viol, irq;
    logic        low_seen, viol_seen;
    logic [7:0]  div_wd, div_rd, cpu_cnt, bus_cnt;
    logic [15:0] ahb_wd, ahb_mask, sys_en;
    logic [31:0] apb_wd, apb_mask, per_en;
    int          err_count, checked;

    mclkpg_top mclkpg_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .div_we_i(div_we),
        .div_wdata_i(div_wd), .ahb_mask_we_i(ahb_we), .ahb_mask_wdata_i(ahb_wd),
        .apb_mask_we_i(apb_we), .apb_mask_wdata_i(apb_wd), .ien_set_i(ien_set),
        .ien_clr_i(ien_clr), .flag_clr_i(flag_clr), .wprot_i(wprot), .dbg_access_i(dbg_acc),
        .dbg_attached_i(dbg_att), .sleep_i(sleep), .cpu_stop_i(cpu_stop),
        .div_rdata_o(div_rd), .clock_ready_flag_o(flag), .irq_en_o(ien),
        .ahb_mask_o(ahb_mask), .apb_mask_o(apb_mask), .cpu_clk_en_o(cpu_en),
        .system_bus_clock_en_o(sys_en), .peripheral_bus_clock_en_o(per_en),
        .prot_violation_o(viol), .irq_o(irq));
    // bit 1 is the controller's own clock, the one that sticks off
    mclkpg_consumer mclkpg_consumer_inst (.clk_i(clk_i), .clr_i(clr), .cpu_en_i(cpu_en),
        .bus_en_i(per_en[1]), .cpu_cnt_o(cpu_cnt), .bus_cnt_o(bus_cnt));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic results();
        $display("Compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    // strobes drop at every edge, so each write is exactly one cycle wide
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_i);
            {div_we, ahb_we, apb_we, ien_set, ien_clr, flag_clr, clr} <= 7'h00;
            #1;
            if (flag === 1'b0) low_seen = 1'b1;
            if (viol === 1'b1) viol_seen = 1'b1;
        end
    endtask : step

    // bounded wait: a divider never applied must not hang the run
    task automatic wait_flag();
        for (int i = 0; i < 300 && flag !== 1'b1; i++) step(1);
        `CHK("ready flag", 1'b1, flag)
        if (flag !== 1'b1) results();
    endtask : wait_flag

    task automatic measure(input logic [7:0] c, input logic [7:0] b);
        @(posedge clk_i) clr <= 1'b1;
        step(41);
        `CHK("cpu ticks", c, cpu_cnt)
        `CHK("bus ticks", b, bus_cnt)
    endtask : measure

    task automatic wr_div(input logic [7:0] d);
        @(posedge clk_i) begin
            div_we <= 1'b1;
            div_wd <= d;
        end
        low_seen  = 1'b0;
        viol_seen = 1'b0;
        step(4);
    endtask : wr_div

    task automatic wr_apb(input logic [31:0] d);
        @(posedge clk_i) begin
            apb_we <= 1'b1;
            apb_wd <= d;
        end
        step(2);
    endtask : wr_apb

    // level inputs move at a rising edge; the design sees them one edge later
    task automatic levels(input logic [4:0] v);
        @(posedge clk_i) {wprot, dbg_acc, dbg_att, sleep, cpu_stop} <= v;
    endtask : levels

    task automatic t_reset_state();
        `CHK("divider", 8'h01, div_rd)
        `CHK("apb mask", 32'h000FFFFF, apb_mask)
        `CHK("ahb mask", 16'h01FF, ahb_mask)
        `CHK("irq enable", 1'b0, ien)
        measure(8'd40, 8'd40);
        `CHK("ahb enables", 16'h01FF, sys_en)
    endtask : t_reset_state

    task automatic t_divide();
        @(posedge clk_i) ien_set <= 1'b1;
        step(1);
        `CHK("irq enable set", 1'b1, ien)
        wr_div(8'h04);
        `CHK("flag low", 1'b1, low_seen)
        wait_flag();
        `CHK("irq", 1'b1, irq)
        measure(8'd10, 8'd10);
        @(posedge clk_i) ien_clr <= 1'b1;
        step(2);
        `CHK("irq disabled", 1'b0, irq)
    endtask : t_divide

    task automatic t_bad_div();
        wr_div(8'h03);
        `CHK("violation", 1'b1, viol_seen)
        `CHK("bad divider", 8'h03, div_rd)
        wait_flag();
        measure(8'd10, 8'd10);
    endtask : t_bad_div

    task automatic t_protect();
        levels(5'h10);
        wr_div(8'h02);
        `CHK("protected div", 8'h03, div_rd)
        levels(5'h18);
        wr_div(8'h01);
        `CHK("debug div", 8'h01, div_rd)
        wait_flag();
    endtask : t_protect

    // order of levels: protect, debug access, debugger attached, sleep, cpu stop
    task automatic t_sleep();
        levels(5'h19);
        measure(8'd0, 8'd40);
        levels(5'h1E);
        measure(8'd40, 8'd40);
        levels(5'h1A);
        measure(8'd0, 8'd40);
        levels(5'h10);
    endtask : t_sleep

    task automatic t_mask();
        wr_apb(32'h0);
        `CHK("protected apb", 32'h000FFFFF, apb_mask)
        @(posedge clk_i) begin
            ahb_we <= 1'b1;
            ahb_wd <= 16'h00FF;
        end
        step(2);
        `CHK("protected ahb", 16'h01FF, ahb_mask)
        levels(5'h18);
        @(posedge clk_i) ahb_we <= 1'b1;
        step(3);
        `CHK("debug ahb", 16'h00FF, ahb_mask)
        `CHK("ahb gated", 16'h00FF, sys_en)
        wr_apb(32'h000FFFFD);
        `CHK("own bit off", 32'h000FFFFD, apb_mask)
        measure(8'd40, 8'd0);
        wr_apb(32'hFFFFFFFF);
        `CHK("own bit sticks", 32'h000FFFFD, apb_mask)
    endtask : t_mask

    task automatic t_flag_clr();
        @(posedge clk_i) ien_set <= 1'b1;
        step(2);
        `CHK("irq raised", 1'b1, irq)
        levels(5'h10);
        @(posedge clk_i) flag_clr <= 1'b1;
        step(2);
        `CHK("flag clear", 1'b0, flag)
        `CHK("irq clear", 1'b0, irq)
    endtask : t_flag_clr

    task automatic t_mid_reset();
        @(posedge clk_i) rst_n_i <= 1'b0;
        step(2);
        `CHK("cpu enable in reset", 1'b0, cpu_en)
        @(posedge clk_i) rst_n_i <= 1'b1;
        step(3);
        `CHK("apb after reset", 32'h000FFFFF, apb_mask)
        `CHK("flag after reset", 1'b1, flag)
        `CHK("divider after reset", 8'h01, div_rd)
    endtask : t_mid_reset

    initial begin
        {rst_n_i, div_we, ahb_we, apb_we, ien_set, ien_clr, flag_clr, clr} = 8'h00;
        {wprot, dbg_acc, dbg_att, sleep, cpu_stop} = 5'h00;
        {div_wd, ahb_wd, apb_wd} = 56'h0;
        {low_seen, viol_seen} = 2'h0;
        err_count = 0;
        checked   = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        step(3);
        t_reset_state();
        t_divide();
        t_bad_div();
        t_protect();
        t_sleep();
        t_mask();
        t_flag_clr();
        t_mid_reset();
        results();
    end
endmodule : tb
